// ===== xp_pkg.sv
// shared constants and types of the i2c port expander
package xp_pkg;

  // seven-bit address is this fixed nibble followed by the three strap levels
  localparam logic [3:0] ADDR_HI      = 4'h7;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [2:0] PRIME_CNT    = 3'h5;

  // command byte target select, bits sel_hi_bit:sel_lo_bit
  localparam int         SEL_LO_BIT   = 0;
  localparam int         SEL_HI_BIT   = 1;
  localparam logic [1:0] SEL_INPUT    = 2'h0;
  localparam logic [1:0] SEL_OUTPUT   = 2'h1;
  localparam logic [1:0] SEL_INVERT   = 2'h2;
  localparam logic [1:0] SEL_DIR      = 2'h3;
  localparam logic [7:0] CMD_INPUT    = 8'h00;

  // reset values
  localparam logic [7:0] OUT_RST      = 8'hFF;
  localparam logic [7:0] INV_RST      = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'hFF;
  localparam logic [7:0] CMD_RST      = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACKA = 3'h3,
    ST_RX   = 3'h2,
    ST_ACKR = 3'h6,
    ST_TX   = 3'h7,
    ST_ACKT = 3'h5,
    ST_OTH  = 3'h4
  } xp_state_e_t;

  // synchroniser stages: s1 feeds s2 only, s3 is the filter's previous sample
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [2:0] a1;
    logic [2:0] a2;
  } xp_sync_t;

  typedef struct packed {
    xp_sync_t    sy;
    logic        scl_f;
    logic        sda_f;
    logic        scl_p;
    logic        sda_p;
    logic [7:0]  pin_f;
    xp_state_e_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        first;
    logic        nack;
    logic [7:0]  cmd;
    logic [7:0]  outl;
    logic [7:0]  inv;
    logic [7:0]  dir;
    logic [7:0]  ref_lvl;
    logic [2:0]  prm;
    logic        alert_n;
    logic        sda_oe_n;
    logic        sda_lvl;
  } xp_state_t;

endpackage

// ===== xp_i2c_expander.sv
// eight-bit i2c port expander with change alert
//
// What this block does
// R1: Power-on reset puts every register and the bus state machine at defaults.
// R2: A pin set as input has its driver off, high impedance.
// R3: A pin set as output drives its output latch bit.
// R4: Any edge on an input-mode pin asserts change_alert_n.
// R5: Alert drops by itself when changed inputs return to original levels.
// R6: Reading the input port clears the alert at the ack bit after SCL rises.
// R7: Output pins never raise the alert; foreign bus traffic leaves it alone except in the R9 case.
// R8: Switching a pin to input with a differing level asserts the alert.
// R9: Defect kept: pointer 00h plus foreign read-address ack clears the alert.
// R10: Master rewrites the pointer away from 00h before reading other slaves.
// R11: Master starts with SDA falling while SCL high, then address MSB first.
// R12: On address match the device holds SDA low through the ack clock.
// R13: Strap pins hold steady from start until stop.
// R14: SDA changes only while SCL low; otherwise it is start or stop.
// R15: Master ends with SDA rising while SCL high.
// R16: Every byte is followed by an ack or nack bit from the receiving side.
// R17: Master nack on the last read byte; device releases SDA.
// R18: Slave address is 0111 then the three strap levels.
// R19: Address byte last bit: one reads, zero writes.
// R20: First byte of a write is stored as the command byte.
// R21: Command bits 1:0 pick input, output latch, inversion or direction.
// R22: The selected register serves later reads until a new command byte.
// R23: Input register shows live pins; writes to it are ignored.
// R24: Output latch reads return the latch, not the pin.
// R25: A one in the inversion register inverts the reported input bit.
// R26: A one in the direction register selects input; zero selects output.
// R27: Pins, SCL and SDA are synchronised and single-sample glitches filtered.
`timescale 1ns/1ps
`default_nettype none

module xp_i2c_expander
  import xp_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic [2:0] addr_strap_pins_i,
  input  wire logic [7:0] io_pins_i,
  output logic      [7:0] io_pins_o,
  output logic      [7:0] io_pins_oe_n_o,
  output logic            change_alert_n_o
);

  xp_state_t  q;
  xp_state_t  n;
  logic       rise;
  logic       fall;
  logic       sta;
  logic       sto;
  logic       hit;
  logic       clr;
  logic       primed;
  logic [7:0] eq;
  logic [7:0] diff;
  logic [7:0] rdv;

  function automatic logic [7:0] reg_read(input logic [1:0] sel, input xp_state_t x);
    logic [7:0] v;
    v = x.pin_f ^ x.inv; // see R23 see R25
    case (sel)
      SEL_OUTPUT: v = x.outl; // see R24
      SEL_INVERT: v = x.inv;
      SEL_DIR:    v = x.dir;
      default:    v = x.pin_f ^ x.inv;
    endcase
    return v;
  endfunction

  function automatic logic addr_hit(input logic [7:0] sh, input logic [2:0] strap);
    return sh[7:1] == {ADDR_HI, strap};
  endfunction

  always_comb begin
    n = q;
    // two-flop synchronisers, then a third sample for the glitch filter
    n.sy.scl = {q.sy.scl[1:0], scl_i}; // see R27
    n.sy.sda = {q.sy.sda[1:0], sda_i};
    n.sy.p1  = io_pins_i;
    n.sy.p2  = q.sy.p1;
    n.sy.p3  = q.sy.p2;
    n.sy.a1  = addr_strap_pins_i;
    n.sy.a2  = q.sy.a1;
    if (q.sy.scl[1] == q.sy.scl[2]) begin
      n.scl_f = q.sy.scl[2]; // see R27
    end
    if (q.sy.sda[1] == q.sy.sda[2]) begin
      n.sda_f = q.sy.sda[2];
    end
    eq      = ~(q.sy.p2 ^ q.sy.p3);
    n.pin_f = (q.sy.p2 & eq) | (q.pin_f & ~eq); // see R27
    n.scl_p = q.scl_f;
    n.sda_p = q.sda_f;

    rise = q.scl_f & ~q.scl_p;
    fall = ~q.scl_f & q.scl_p;
    // sda moving while scl stays high is a condition, not data
    sta  = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f; // see R14
    sto  = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f; // see R14
    hit  = addr_hit(q.sh, q.sy.a2); // see R18
    rdv  = reg_read(q.cmd[SEL_HI_BIT:SEL_LO_BIT], q); // see R21 see R22
    clr  = 1'b0;

    if (sto) begin
      n.st       = ST_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (sta) begin
      n.st       = ST_ADDR;
      n.cnt      = 4'h0;
      n.sda_oe_n = 1'b1;
    end else begin
      case (q.st)
        ST_ADDR: begin
          if (rise) begin
            n.sh  = {q.sh[6:0], q.sda_f};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == BYTE_BITS) begin
            n.rw  = q.sh[0]; // see R19
            n.cnt = 4'h0;
            if (hit) begin
              n.st       = ST_ACKA;
              n.sda_oe_n = 1'b0; // see R12
            end else begin
              n.st = ST_OTH;
            end
          end
        end
        ST_OTH: begin
          // foreign ack bit; only the pointer-00h read case touches the alert
          if (rise) begin
            if (!q.sda_f && q.rw && q.cmd == CMD_INPUT) begin
              clr = 1'b1; // see R9
            end
            n.st = ST_IDLE; // see R7
          end
        end
        ST_ACKA: begin
          if (fall) begin
            n.cnt = 4'h0;
            if (q.rw) begin
              n.sh       = rdv;
              n.sda_oe_n = rdv[7];
              n.st       = ST_TX;
            end else begin
              n.sda_oe_n = 1'b1;
              n.first    = 1'b1; // see R20
              n.st       = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            n.sh  = {q.sh[6:0], q.sda_f};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == BYTE_BITS) begin
            n.sda_oe_n = 1'b0; // see R16
            n.st       = ST_ACKR;
            if (q.first) begin
              n.cmd = q.sh; // see R20
            end else begin
              case (q.cmd[SEL_HI_BIT:SEL_LO_BIT])
                SEL_OUTPUT: n.outl = q.sh; // see R3
                SEL_INVERT: n.inv  = q.sh; // see R25
                SEL_DIR:    n.dir  = q.sh; // see R26
                default:    n.outl = q.outl; // see R23
              endcase
            end
          end
        end
        ST_ACKR: begin
          if (fall) begin
            n.sda_oe_n = 1'b1;
            n.cnt      = 4'h0;
            n.first    = 1'b0;
            n.st       = ST_RX;
          end
        end
        ST_TX: begin
          if (fall) begin
            if (q.cnt == BYTE_BITS - 4'h1) begin
              n.sda_oe_n = 1'b1;
              n.st       = ST_ACKT;
            end else begin
              n.sh       = {q.sh[6:0], 1'b0};
              n.sda_oe_n = q.sh[6];
              n.cnt      = q.cnt + 4'h1;
            end
          end
        end
        ST_ACKT: begin
          if (rise) begin
            n.nack = q.sda_f; // see R16
            if (q.cmd[SEL_HI_BIT:SEL_LO_BIT] == SEL_INPUT) begin
              clr = 1'b1; // see R6
            end
          end else if (fall) begin
            if (q.nack) begin
              n.st = ST_IDLE; // see R17
            end else begin
              n.sh       = rdv;
              n.sda_oe_n = rdv[7];
              n.cnt      = 4'h0;
              n.st       = ST_TX;
            end
          end
        end
        ST_IDLE: begin
          n.sda_oe_n = 1'b1;
        end
        default: begin
          n.st       = ST_IDLE;
          n.sda_oe_n = 1'b1;
        end
      endcase
    end

    // alert compares input-mode pins against the levels seen at the last clear
    primed = (q.prm == PRIME_CNT);
    diff   = (q.pin_f ^ q.ref_lvl) & q.dir; // see R7 see R8
    if (!primed) begin
      n.prm     = q.prm + 3'h1;
      n.ref_lvl = q.pin_f;
    end else if (clr) begin
      n.ref_lvl = q.pin_f;
    end
    n.alert_n = ~(primed & (|diff) & ~clr); // see R4 see R5
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q          <= '0; // see R1
      q.scl_f    <= 1'b1;
      q.sda_f    <= 1'b1;
      q.scl_p    <= 1'b1;
      q.sda_p    <= 1'b1;
      // sync stages start at the idle bus level so no false edge follows reset
      q.sy.scl   <= 3'h7; // see R27
      q.sy.sda   <= 3'h7;
      q.st       <= ST_IDLE;
      q.cmd      <= CMD_RST;
      q.outl     <= OUT_RST;
      q.inv      <= INV_RST;
      q.dir      <= DIR_RST;
      q.alert_n  <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign sda_o            = q.sda_lvl;
  assign sda_oe_n_o       = q.sda_oe_n;
  assign io_pins_o        = q.outl; // see R3
  assign io_pins_oe_n_o   = q.dir; // see R2 see R26
  assign change_alert_n_o = q.alert_n;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_addr_done;
    q.st == ST_ADDR && fall && q.cnt == BYTE_BITS && !sta && !sto;
  endsequence

  sequence s_rx_done;
    q.st == ST_RX && fall && q.cnt == BYTE_BITS && !sta && !sto;
  endsequence

  property p_ack_addr;
    s_addr_done ##0 hit |=> !sda_oe_n_o && q.st == ST_ACKA;
  endproperty
  a_ack_addr: assert property (p_ack_addr) // see R12
    else $error("matching address not acknowledged");

  property p_ack_hold;
    q.st == ST_ACKA && !fall && !sta && !sto |=> !sda_oe_n_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold) // see R12
    else $error("ack released before scl fall");

  property p_no_match;
    s_addr_done ##0 !hit |=> sda_oe_n_o [*2];
  endproperty
  a_no_match: assert property (p_no_match) // see R18
    else $error("foreign address acknowledged");

  property p_rw;
    s_addr_done |=> q.rw == $past(q.sh[0]);
  endproperty
  a_rw: assert property (p_rw) // see R19
    else $error("direction bit not captured");

  property p_cmd;
    s_rx_done ##0 q.first |=> q.cmd == $past(q.sh) && !sda_oe_n_o;
  endproperty
  a_cmd: assert property (p_cmd) // see R20
    else $error("command byte not stored");

  property p_out_wr;
    s_rx_done ##0 (!q.first && q.cmd[1:0] == SEL_OUTPUT) |=> io_pins_o == $past(q.sh);
  endproperty
  a_out_wr: assert property (p_out_wr) // see R3
    else $error("output latch not written");

  property p_dir_wr;
    s_rx_done ##0 (!q.first && q.cmd[1:0] == SEL_DIR) |=> io_pins_oe_n_o == $past(q.sh);
  endproperty
  a_dir_wr: assert property (p_dir_wr) // see R26
    else $error("direction write did not steer drivers");

  property p_in_ro;
    s_rx_done ##0 (!q.first && q.cmd[1:0] == SEL_INPUT) |=> $stable(q.outl) && $stable(q.inv) && $stable(q.dir);
  endproperty
  a_in_ro: assert property (p_in_ro) // see R23
    else $error("write to input register changed state");

  property p_alert_set;
    primed && (|diff) && !clr |=> !change_alert_n_o;
  endproperty
  a_alert_set: assert property (p_alert_set) // see R4
    else $error("alert not raised on input change");

  property p_alert_rel;
    !(|diff) |=> change_alert_n_o;
  endproperty
  a_alert_rel: assert property (p_alert_rel) // see R5
    else $error("alert held with inputs back at original");

  property p_out_quiet;
    q.dir == 8'h00 |=> change_alert_n_o;
  endproperty
  a_out_quiet: assert property (p_out_quiet) // see R7
    else $error("output pin raised alert");

  property p_read_clr;
    q.st == ST_ACKT && rise && !sto && !sta && q.cmd[1:0] == SEL_INPUT && primed
      |=> change_alert_n_o && q.ref_lvl == $past(q.pin_f);
  endproperty
  a_read_clr: assert property (p_read_clr) // see R6
    else $error("input read did not clear alert");

  property p_stop;
    sto |=> sda_oe_n_o && q.st == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) // see R17
    else $error("sda not released after stop");

endmodule // xp_i2c_expander

`default_nettype wire

// ===== xp_master_model.sv
// i2c bus master model that drives the expander's serial link
`timescale 1ns/1ps
`default_nettype none

module xp_master_model (
  output var logic scl_o,
  output var logic sda_o,
  input  wire logic sda_i
);
  logic in_frame;

  initial begin
    scl_o    = 1'b1;
    sda_o    = 1'b1;
    in_frame = 1'b0;
  end

  // data moves only while scl is low; the line is sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    scl_o = 1'b0;
    #80 sda_o = b;
    #120 scl_o = 1'b1;
    #100 r = sda_i;
    #20;
  endtask

  // a repeated start first lowers scl so the data line may rise without a stop
  task automatic start();
    if (in_frame) begin
      scl_o = 1'b0;
      #160 sda_o = 1'b1;
      #160 scl_o = 1'b1;
    end
    #120 sda_o = 1'b0;
    #120 in_frame = 1'b1;
  endtask

  task automatic stop();
    scl_o = 1'b0;
    #80 sda_o = 1'b0;
    #120 scl_o = 1'b1;
    #120 sda_o = 1'b1;
    #200 in_frame = 1'b0;
  endtask

  // rel low pulls the ack slot itself, as another slave acking would
  task automatic wb(input logic [7:0] d, input logic rel, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(rel, a);
  endtask

  task automatic rb(output logic [7:0] d, input logic nk);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nk, r);
  endtask

endmodule // xp_master_model

`default_nettype wire

// ===== xp_i2c_expander_bench.sv
// self-checking bench for the i2c port expander
`timescale 1ns/1ps
`default_nettype none

module xp_i2c_expander_bench;
  logic       clk;
  logic       rstn;
  logic       m_scl;
  logic       m_sda;
  logic       sda_oe_n;
  logic       sda_d;
  logic       alert_n;
  logic [2:0] strap;
  logic [7:0] ext;
  logic [7:0] pins_o;
  logic [7:0] pins_oe_n;
  logic [7:0] rd_v;
  int         failures;
  int         checks_done;
  // pulled-up data line; port pins resolved from both drivers
  wire        sda  = m_sda & (sda_oe_n | sda_d);
  wire  [7:0] pins = (pins_oe_n & ext) | (~pins_oe_n & pins_o);

  xp_i2c_expander xp_i2c_expander_inst (
    .ref_clk_i(clk), .resetn_i(rstn), .scl_i(m_scl), .sda_i(sda), .sda_o(sda_d),
    .sda_oe_n_o(sda_oe_n), .addr_strap_pins_i(strap), .io_pins_i(pins), .io_pins_o(pins_o),
    .io_pins_oe_n_o(pins_oe_n), .change_alert_n_o(alert_n));

  xp_master_model xp_master_model_inst (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // waits end just after an edge, so outputs are looked at once settled
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask

  task automatic wait_alert(input logic e);
    for (int i = 0; i < 60 && alert_n !== e; i++) begin
      @(posedge clk);
      #2;
    end
    chk("alert", {7'h0, e}, {7'h0, alert_n});
    if (alert_n !== e) stop_test();
  endtask

  task automatic set_ext(input logic [7:0] v);
    @(posedge clk);
    #2 ext = v;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] v, input logic two);
    logic a;
    xp_master_model_inst.start();
    xp_master_model_inst.wb(8'h7A, 1'b1, a);
    chk("addr ack", 8'h00, {7'h0, a});
    xp_master_model_inst.wb(c, 1'b1, a);
    chk("cmd ack", 8'h00, {7'h0, a});
    if (two) begin
      xp_master_model_inst.wb(v, 1'b1, a);
      chk("data ack", 8'h00, {7'h0, a});
    end
    xp_master_model_inst.stop();
  endtask

  task automatic rd(output logic [7:0] d);
    logic a;
    xp_master_model_inst.start();
    xp_master_model_inst.wb(8'h7B, 1'b1, a);
    chk("read ack", 8'h00, {7'h0, a});
    xp_master_model_inst.rb(d, 1'b1);
    chk("sda release", 8'h01, {7'h0, sda_oe_n});
    xp_master_model_inst.stop();
  endtask

  // pointer write, then a repeated start straight into the read
  task automatic rdp(input logic [7:0] p, input logic [7:0] e, input string n);
    logic a;
    xp_master_model_inst.start();
    xp_master_model_inst.wb(8'h7A, 1'b1, a);
    chk("addr ack", 8'h00, {7'h0, a});
    xp_master_model_inst.wb(p, 1'b1, a);
    chk("cmd ack", 8'h00, {7'h0, a});
    rd(rd_v);
    chk(n, e, rd_v);
  endtask

  // another slave acks a read address while the expander only listens
  task automatic foreign();
    logic a;
    xp_master_model_inst.start();
    xp_master_model_inst.wb(8'h43, 1'b0, a);
    xp_master_model_inst.stop();
  endtask

  task automatic t_reset();
    chk("oe_n", 8'hFF, pins_oe_n);
    chk("latch out", 8'hFF, pins_o);
    chk("alert", 8'h01, {7'h0, alert_n});
    rd(rd_v);
    chk("input", 8'h3C, rd_v);
    for (int i = 1; i < 4; i++) rdp(i[7:0], (i == 2) ? 8'h00 : 8'hFF, "reset value");
    $display("t_reset done");
  endtask

  task automatic t_regs();
    logic a;
    wr(8'h01, 8'hA5, 1'b1);
    wr(8'h03, 8'h0F, 1'b1);
    chk("latch out", 8'hA5, pins_o);
    chk("oe_n", 8'h0F, pins_oe_n);
    wr(8'h00, 8'h55, 1'b1);
    rdp(8'h00, 8'hAC, "input live");
    rdp(8'h01, 8'hA5, "latch read");
    wr(8'h02, 8'hF0, 1'b1);
    rdp(8'h00, 8'h5C, "inverted");
    // two-byte read: master acks the first byte and nacks the second
    xp_master_model_inst.start();
    xp_master_model_inst.wb(8'h7B, 1'b1, a);
    chk("read ack", 8'h00, {7'h0, a});
    xp_master_model_inst.rb(rd_v, 1'b0);
    chk("pointer kept", 8'h5C, rd_v);
    xp_master_model_inst.rb(rd_v, 1'b1);
    chk("second byte", 8'h5C, rd_v);
    chk("sda release", 8'h01, {7'h0, sda_oe_n});
    xp_master_model_inst.stop();
    wr(8'h02, 8'h00, 1'b1);
    wr(8'h03, 8'h00, 1'b1);
    chk("oe_n", 8'h00, pins_oe_n);
    chk("alert", 8'h01, {7'h0, alert_n});
    $display("t_regs done");
  endtask

  task automatic t_addr();
    logic a;
    for (int i = 0; i < 8; i++) begin
      xp_master_model_inst.start();
      xp_master_model_inst.wb({4'h7, i[2:0], 1'b0}, 1'b1, a);
      xp_master_model_inst.stop();
      chk("addr match", {7'h0, i != 5}, {7'h0, a});
    end
    $display("t_addr done");
  endtask

  task automatic t_alert();
    wr(8'h03, 8'h7F, 1'b1);
    rdp(8'h00, 8'hBC, "input");
    wait_alert(1'b1);
    set_ext(8'h3D);
    set_ext(8'h3C);
    settle(20);
    chk("glitch", 8'h01, {7'h0, alert_n});
    set_ext(8'h3D);
    wait_alert(1'b0);
    set_ext(8'h3C);
    wait_alert(1'b1);
    set_ext(8'h1C);
    wait_alert(1'b0);
    rd(rd_v);
    chk("input", 8'h9C, rd_v);
    wait_alert(1'b1);
    wr(8'h01, 8'h25, 1'b1);
    settle(20);
    chk("output quiet", 8'h01, {7'h0, alert_n});
    wr(8'h03, 8'hFF, 1'b1);
    wait_alert(1'b0);
    $display("t_alert done");
  endtask

  task automatic t_foreign();
    wr(8'h00, 8'h00, 1'b0);
    foreign();
    wait_alert(1'b1);
    wr(8'h01, 8'h00, 1'b0);
    set_ext(8'h3C);
    wait_alert(1'b0);
    foreign();
    settle(20);
    chk("foreign quiet", 8'h00, {7'h0, alert_n});
    $display("t_foreign done");
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    rstn = 1'b0;
    strap = 3'h5;
    ext = 8'h3C;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    settle(12);
    t_reset();
    t_regs();
    t_addr();
    t_alert();
    t_foreign();
    stop_test();
  end

endmodule // xp_i2c_expander_bench

`default_nettype wire
